// ==== logic/uesc_pkg.sv ====
// Purpose: shared constants for the endpoint status and control block
// Assumes: 8-bit register data, byte addresses on a plain register port
// Notes: status codes are shared by every endpoint direction
package uesc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_FAULT = 8'h00;
  localparam logic [7:0] ADDR_EP0 = 8'h01;
  localparam logic [7:0] ADDR_TX_BASE = 8'h02;
  localparam logic [7:0] ADDR_EP2RX = 8'h07;
  localparam int NUM_TX_EP = 5;
  // endpoint 0 field positions
  localparam int EP0_DONE_BIT = 7;
  localparam int EP0_TXTOG_BIT = 6;
  localparam int EP0_TXSTAT_LSB = 4;
  localparam int EP0_RXTOG_BIT = 2;
  localparam int EP0_RXSTAT_LSB = 0;
  // transmit and endpoint 2 receive field positions
  localparam int EPN_DONE_BIT = 3;
  localparam int EPN_TOG_BIT = 2;
  localparam int EPN_STAT_LSB = 0;
  // reset values
  localparam logic [7:0] EP_RESET_VAL = 8'h00;
  localparam logic [2:0] FAULT_RESET_VAL = 3'h0;
  // status field code
  typedef enum logic [1:0] {
    UESC_DISABLED = 2'h0,
    UESC_STALL = 2'h1,
    UESC_NAK = 2'h2,
    UESC_VALID = 2'h3
  } uesc_stat_t;
  // fault kind code
  typedef enum logic [2:0] {
    UESC_ERR_NONE = 3'h0,
    UESC_ERR_STUFF = 3'h1,
    UESC_ERR_CRC = 3'h2,
    UESC_ERR_EOP = 3'h3,
    UESC_ERR_PID = 3'h4,
    UESC_ERR_MEM = 3'h5,
    UESC_ERR_OTHER = 3'h6
  } uesc_fault_t;
  // one-hot answer: bit0 ignore, bit1 stall, bit2 nak, bit3 handle
  typedef logic [3:0] uesc_hs_t;
  function automatic uesc_hs_t uesc_decode(input logic [1:0] stat);
    uesc_hs_t hs;
    hs = 4'h0;
    hs[stat] = 1'b1;
    return hs;
  endfunction
endpackage

// ==== logic/uesc_txep.sv ====
// Purpose: transmit control register of one endpoint 1 to 5
// Assumes: tx_ack is one cycle per ACK returned by the host
// Notes: done flag is cleared by writing zero to it
`timescale 1ns/1ps
module uesc_txep (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic usb_rst,
  // software write
  input wire logic wr_en,
  input wire logic [3:0] wdata,
  // engine event
  input wire logic tx_ack,
  // register state
  output logic done_ff,
  output logic tog_ff,
  output logic [1:0] stat_ff
);
  logic ack_ok;
  assign ack_ok = tx_ack && (stat_ff == uesc_pkg::UESC_VALID);

  // done flag: hardware set beats a software clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_ff <= 1'b0;
    end else if (ack_ok) begin
      done_ff <= 1'b1; // RULE_16 RULE_23 RULE_24
    end else if (wr_en && !wdata[uesc_pkg::EPN_DONE_BIT]) begin
      done_ff <= 1'b0;
    end
  end

  // toggle and status: bus reset, then hardware, then software
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_ff <= 1'b0;
      stat_ff <= uesc_pkg::UESC_DISABLED;
    end else if (usb_rst) begin
      tog_ff <= 1'b0; // RULE_15
      stat_ff <= uesc_pkg::UESC_DISABLED;
    end else if (ack_ok) begin
      tog_ff <= ~tog_ff; // RULE_06
      stat_ff <= uesc_pkg::UESC_NAK; // RULE_18 RULE_24
    end else if (wr_en) begin
      tog_ff <= wdata[uesc_pkg::EPN_TOG_BIT]; // RULE_07
      stat_ff <= wdata[uesc_pkg::EPN_STAT_LSB +: 2]; // RULE_17
    end
  end

  a_tx_done_nak: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_24
    ack_ok && !usb_rst |=> done_ff && stat_ff == uesc_pkg::UESC_NAK)
    else $error("tx done and nak not set together");
  a_tx_tog_flip: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_06
    !ack_ok && !wr_en && !usb_rst |=> $stable(tog_ff))
    else $error("tx toggle changed without ack");
endmodule

// ==== logic/uesc_top.sv ====
// Purpose: endpoint status, toggle and fault-kind registers of a USB device
// Assumes: protocol engine gives one-cycle event pulses, synchronous inputs
// Notes: registers are 8 bits wide; read data appears one cycle after rd
//
// Contract
// [RULE_01] three-bit code names the last error
// [RULE_02] load code on error, clear with flag
// [RULE_03] bus reset clears ep0 bits six-four, two-zero
// [RULE_04] ep0 correct transfer sets ep0 done flag
// [RULE_05] setup forces ep0 tx toggle to one
// [RULE_06] tx toggle flips only after host ack
// [RULE_07] software may write both toggle bits
// [RULE_08] ep0 tx status decodes four answers
// [RULE_09] ep0 correct transfer sets both nak
// [RULE_10] setup clears ep0 rx toggle
// [RULE_11] rx toggle flips on matching good packet
// [RULE_12] ep0 rx status uses same code
// [RULE_13] setup not disabled: acknowledge, both nak
// [RULE_14] stall sent sets both ep0 fields stall
// [RULE_15] bus reset clears bits two-zero elsewhere
// [RULE_16] ep1-5 correct transmit sets tx done
// [RULE_17] ep1-5 tx status decodes four answers
// [RULE_18] correct transfer forces ep1-5 status nak
// [RULE_19] reserved bits always read zero
// [RULE_20] separate endpoint 2 receive register exists
// [RULE_21] ep2 rx status code, nak after transfer
// [RULE_22] ep2 rx done flag at bit three
// [RULE_23] hardware done set beats software clear
// [RULE_24] done flag and status update together
`timescale 1ns/1ps
module uesc_top #(
  parameter int NUM_TX = uesc_pkg::NUM_TX_EP
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // interface resets
  input wire logic bus_reset,
  input wire logic force_iface_reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // error events
  input wire logic err_event,
  input wire logic [2:0] err_code,
  input wire logic err_flag_clear,
  // endpoint 0 events
  input wire logic ep0_setup,
  input wire logic ep0_tx_ack,
  input wire logic ep0_rx_ok,
  input wire logic ep0_rx_pid,
  input wire logic ep0_stall_sent,
  output logic ep0_setup_ack,
  // endpoint 1 to 5 transmit events
  input wire logic [NUM_TX-1:0] ep_tx_ack,
  // endpoint 2 receive events
  input wire logic ep2_rx_ok,
  input wire logic ep2_rx_pid,
  // state toward the engine
  output logic [3:0] ep0_tx_hs,
  output logic [3:0] ep0_rx_hs,
  output logic ep0_tx_tog,
  output logic ep0_rx_tog,
  output logic [NUM_TX*4-1:0] ep_tx_hs,
  output logic [NUM_TX-1:0] ep_tx_tog,
  output logic [3:0] ep2_rx_hs,
  output logic ep2_rx_tog,
  output logic ep_done_any
);
  logic usb_rst;
  logic [2:0] fault_kind_ff;
  logic ep0_done_ff;
  logic ep0_txtog_ff;
  logic ep0_rxtog_ff;
  logic [1:0] ep0_txstat_ff;
  logic [1:0] ep0_rxstat_ff;
  logic ep2rx_done_ff;
  logic ep2rx_tog_ff;
  logic [1:0] ep2rx_stat_ff;
  logic [NUM_TX-1:0] tx_done;
  logic [NUM_TX-1:0] tx_tog;
  logic [NUM_TX*2-1:0] tx_stat;
  logic [NUM_TX-1:0] tx_wr;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic wr_ep0;
  logic wr_ep2rx;
  logic ep0_tx_good;
  logic ep0_rx_good;
  logic ep0_ctr;
  logic ep2_rx_good;

  // interface reset: bus reset or forced reset held by software
  assign usb_rst = bus_reset || force_iface_reset;

  // write decode
  assign wr_ep0 = reg_wr && (reg_addr == uesc_pkg::ADDR_EP0);
  assign wr_ep2rx = reg_wr && (reg_addr == uesc_pkg::ADDR_EP2RX);

  // endpoint 0 and endpoint 2 receive completion events
  assign ep0_setup_ack = ep0_setup && (ep0_rxstat_ff != uesc_pkg::UESC_DISABLED); // RULE_13
  assign ep0_tx_good = ep0_tx_ack && (ep0_txstat_ff == uesc_pkg::UESC_VALID);
  assign ep0_rx_good = ep0_rx_ok && (ep0_rxstat_ff == uesc_pkg::UESC_VALID)
                       && (ep0_rx_pid == ep0_rxtog_ff); // RULE_11
  assign ep0_ctr = ep0_tx_good || ep0_rx_good || ep0_setup_ack;
  assign ep2_rx_good = ep2_rx_ok && (ep2rx_stat_ff == uesc_pkg::UESC_VALID)
                       && (ep2_rx_pid == ep2rx_tog_ff); // RULE_11

  // fault kind: a new error wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_kind_ff <= uesc_pkg::FAULT_RESET_VAL;
    end else if (err_event) begin
      fault_kind_ff <= err_code; // RULE_01 RULE_02
    end else if (err_flag_clear) begin
      fault_kind_ff <= uesc_pkg::UESC_ERR_NONE; // RULE_02
    end
  end

  // endpoint 0 done flag survives bus reset, cleared by writing zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ep0_done_ff <= 1'b0;
    end else if (ep0_ctr) begin
      ep0_done_ff <= 1'b1; // RULE_04 RULE_23
    end else if (wr_ep0 && !reg_wdata[uesc_pkg::EP0_DONE_BIT]) begin
      ep0_done_ff <= 1'b0;
    end
  end

  // endpoint 0 status fields: reset, stall, completion, then software
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ep0_txstat_ff <= uesc_pkg::UESC_DISABLED;
      ep0_rxstat_ff <= uesc_pkg::UESC_DISABLED;
    end else if (usb_rst) begin
      ep0_txstat_ff <= uesc_pkg::UESC_DISABLED; // RULE_03
      ep0_rxstat_ff <= uesc_pkg::UESC_DISABLED;
    end else if (ep0_stall_sent) begin
      ep0_txstat_ff <= uesc_pkg::UESC_STALL; // RULE_14
      ep0_rxstat_ff <= uesc_pkg::UESC_STALL;
    end else if (ep0_ctr) begin
      ep0_txstat_ff <= uesc_pkg::UESC_NAK; // RULE_09 RULE_13
      ep0_rxstat_ff <= uesc_pkg::UESC_NAK;
    end else if (wr_ep0) begin
      ep0_txstat_ff <= reg_wdata[uesc_pkg::EP0_TXSTAT_LSB +: 2]; // RULE_08
      ep0_rxstat_ff <= reg_wdata[uesc_pkg::EP0_RXSTAT_LSB +: 2]; // RULE_12
    end
  end

  // endpoint 0 transmit toggle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ep0_txtog_ff <= 1'b0;
    end else if (usb_rst) begin
      ep0_txtog_ff <= 1'b0; // RULE_03
    end else if (ep0_setup_ack) begin
      ep0_txtog_ff <= 1'b1; // RULE_05
    end else if (ep0_tx_good) begin
      ep0_txtog_ff <= ~ep0_txtog_ff; // RULE_06
    end else if (wr_ep0) begin
      ep0_txtog_ff <= reg_wdata[uesc_pkg::EP0_TXTOG_BIT]; // RULE_07
    end
  end

  // endpoint 0 receive toggle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ep0_rxtog_ff <= 1'b0;
    end else if (usb_rst) begin
      ep0_rxtog_ff <= 1'b0; // RULE_03
    end else if (ep0_setup_ack) begin
      ep0_rxtog_ff <= 1'b0; // RULE_10
    end else if (ep0_rx_good) begin
      ep0_rxtog_ff <= ~ep0_rxtog_ff; // RULE_11
    end else if (wr_ep0) begin
      ep0_rxtog_ff <= reg_wdata[uesc_pkg::EP0_RXTOG_BIT]; // RULE_07
    end
  end

  // endpoint 2 receive done flag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ep2rx_done_ff <= 1'b0;
    end else if (ep2_rx_good) begin
      ep2rx_done_ff <= 1'b1; // RULE_22 RULE_23 RULE_24
    end else if (wr_ep2rx && !reg_wdata[uesc_pkg::EPN_DONE_BIT]) begin
      ep2rx_done_ff <= 1'b0;
    end
  end

  // endpoint 2 receive toggle and status
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ep2rx_tog_ff <= 1'b0;
      ep2rx_stat_ff <= uesc_pkg::UESC_DISABLED;
    end else if (usb_rst) begin
      ep2rx_tog_ff <= 1'b0; // RULE_15
      ep2rx_stat_ff <= uesc_pkg::UESC_DISABLED;
    end else if (ep2_rx_good) begin
      ep2rx_tog_ff <= ~ep2rx_tog_ff; // RULE_11
      ep2rx_stat_ff <= uesc_pkg::UESC_NAK; // RULE_21 RULE_24
    end else if (wr_ep2rx) begin
      ep2rx_tog_ff <= reg_wdata[uesc_pkg::EPN_TOG_BIT]; // RULE_07
      ep2rx_stat_ff <= reg_wdata[uesc_pkg::EPN_STAT_LSB +: 2]; // RULE_20 RULE_21
    end
  end

  // transmit registers of endpoints 1 to 5
  for (genvar i = 0; i < NUM_TX; i++) begin : g_tx
    assign tx_wr[i] = reg_wr && (reg_addr == uesc_pkg::ADDR_TX_BASE + 8'(i));
    uesc_txep u_txep (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .usb_rst(usb_rst),
      .wr_en(tx_wr[i]),
      .wdata(reg_wdata[3:0]),
      .tx_ack(ep_tx_ack[i]),
      .done_ff(tx_done[i]),
      .tog_ff(tx_tog[i]),
      .stat_ff(tx_stat[i*2 +: 2])
    );
    assign ep_tx_hs[i*4 +: 4] = uesc_pkg::uesc_decode(tx_stat[i*2 +: 2]); // RULE_17
  end

  // read mux: reserved bits and unmapped addresses give zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr == uesc_pkg::ADDR_FAULT) begin
      nxt_rdata = {5'h00, fault_kind_ff}; // RULE_19
    end else if (reg_addr == uesc_pkg::ADDR_EP0) begin
      nxt_rdata = {ep0_done_ff, ep0_txtog_ff, ep0_txstat_ff, 1'b0,
                   ep0_rxtog_ff, ep0_rxstat_ff}; // RULE_19
    end else if (reg_addr == uesc_pkg::ADDR_EP2RX) begin
      nxt_rdata = {4'h0, ep2rx_done_ff, ep2rx_tog_ff, ep2rx_stat_ff}; // RULE_19
    end else begin
      for (int j = 0; j < NUM_TX; j++) begin
        if (reg_addr == uesc_pkg::ADDR_TX_BASE + 8'(j)) begin
          nxt_rdata = {4'h0, tx_done[j], tx_tog[j], tx_stat[j*2 +: 2]}; // RULE_19
        end
      end
    end
  end

  // read data register, valid the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // register read data and outputs toward the engine
  assign reg_rdata = rdata_ff;
  assign ep0_tx_hs = uesc_pkg::uesc_decode(ep0_txstat_ff); // RULE_08
  assign ep0_rx_hs = uesc_pkg::uesc_decode(ep0_rxstat_ff); // RULE_12
  assign ep0_tx_tog = ep0_txtog_ff;
  assign ep0_rx_tog = ep0_rxtog_ff;
  assign ep_tx_tog = tx_tog;
  assign ep2_rx_hs = uesc_pkg::uesc_decode(ep2rx_stat_ff); // RULE_21
  assign ep2_rx_tog = ep2rx_tog_ff;
  assign ep_done_any = ep0_done_ff || ep2rx_done_ff || (|tx_done);

  // checks
  a_fault_load: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_02
    err_event |=> fault_kind_ff == $past(err_code))
    else $error("fault kind not loaded");
  a_fault_clear: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_02
    err_flag_clear && !err_event |=> fault_kind_ff == 3'h0)
    else $error("fault kind not cleared");
  a_setup_toggles: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_05
    ep0_setup_ack && !usb_rst |=> ep0_txtog_ff && !ep0_rxtog_ff)
    else $error("setup toggles wrong");
  a_ep0_ctr_nak: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_09
    ep0_ctr && !ep0_stall_sent && !usb_rst |=>
      ep0_txstat_ff == 2'h2 && ep0_rxstat_ff == 2'h2 && ep0_done_ff)
    else $error("ep0 completion not nak");
  a_ep0_stall_both: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_14
    ep0_stall_sent && !usb_rst |=> ep0_txstat_ff == 2'h1 && ep0_rxstat_ff == 2'h1)
    else $error("ep0 stall not on both");
  a_usb_rst_clear: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_03
    usb_rst |=> ep0_txstat_ff == 2'h0 && ep0_rxstat_ff == 2'h0 && !ep0_txtog_ff
      && !ep0_rxtog_ff && ep2rx_stat_ff == 2'h0 && tx_tog == '0)
    else $error("interface reset left state");
  a_done_set_wins: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_23
    ep2_rx_good && wr_ep2rx |=> ep2rx_done_ff)
    else $error("done set lost to clear");
  a_rx_tog_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_11
    !ep0_rx_good && !ep0_setup_ack && !wr_ep0 && !usb_rst |=> $stable(ep0_rxtog_ff))
    else $error("rx toggle moved without cause");
  a_ep0_rsvd_zero: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_19
    reg_rd && reg_addr == uesc_pkg::ADDR_EP0 |=> reg_rdata[3] == 1'b0)
    else $error("reserved ep0 bit not zero");
  a_read_fault: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_01
    reg_rd && reg_addr == uesc_pkg::ADDR_FAULT |=>
      reg_rdata == {5'h00, $past(fault_kind_ff)})
    else $error("fault read mismatch");
endmodule

// ==== verif/uesc_host_model.sv ====
// Purpose: far-side model issuing engine events seen from the USB host
// Assumes: events are one-cycle pulses launched right after a rising edge
// Notes: qualifiers are inverted once their pulse ends so stale values never match
`timescale 1ns/1ps
module uesc_host_model (
  // clock
  input wire logic core_clk,
  // interface resets
  output logic bus_reset,
  output logic force_iface_reset,
  // error events
  output logic err_event,
  output logic [2:0] err_code,
  output logic err_flag_clear,
  // endpoint events
  output logic ep0_setup,
  output logic ep0_tx_ack,
  output logic ep0_rx_ok,
  output logic ep0_rx_pid,
  output logic ep0_stall_sent,
  output logic [4:0] ep_tx_ack,
  output logic ep2_rx_ok,
  output logic ep2_rx_pid
);
  // idle levels at time zero
  initial begin
    {bus_reset, force_iface_reset, err_event, err_flag_clear} = 4'h0;
    {ep0_setup, ep0_tx_ack, ep0_rx_ok, ep0_stall_sent, ep2_rx_ok} = 5'h00;
    {err_code, ep0_rx_pid, ep2_rx_pid, ep_tx_ack} = 10'h000;
  end
  // one event of kind k with qualifier v, held for exactly one cycle
  task automatic fire(input int k, input logic [2:0] v);
    @(posedge core_clk);
    case (k)
      0: begin err_event <= 1'b1; err_code <= v; end
      1: err_flag_clear <= 1'b1;
      2: ep0_setup <= 1'b1;
      3: ep0_tx_ack <= 1'b1; // ack only after data sent
      4: begin ep0_rx_ok <= 1'b1; ep0_rx_pid <= v[0]; end
      5: ep0_stall_sent <= 1'b1;
      6: ep_tx_ack[v] <= 1'b1;
      7: begin ep2_rx_ok <= 1'b1; ep2_rx_pid <= v[0]; end
      8: bus_reset <= 1'b1;
      default: force_iface_reset <= 1'b1;
    endcase
    @(posedge core_clk);
    {bus_reset, force_iface_reset, err_event, err_flag_clear} <= 4'h0;
    {ep0_setup, ep0_tx_ack, ep0_rx_ok, ep0_stall_sent, ep2_rx_ok} <= 5'h00;
    ep_tx_ack <= 5'h00;
    err_code <= ~v;
    ep0_rx_pid <= ~v[0];
    ep2_rx_pid <= ~v[0];
  endtask
endmodule

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the endpoint status and control block
// Assumes: read data valid only in the cycle after the read strobe
// Notes: reads queue their expectation, a negedge monitor compares
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] ep0_tx_hs, ep0_rx_hs, ep2_rx_hs;
  logic [19:0] ep_tx_hs;
  logic [4:0] ep_tx_ack, ep_tx_tog;
  logic [2:0] err_code, c;
  logic bus_reset, force_iface_reset, err_event, err_flag_clear, ep0_setup, ep0_tx_ack;
  logic ep0_rx_ok, ep0_rx_pid, ep0_stall_sent, ep2_rx_ok, ep2_rx_pid, ep0_setup_ack;
  logic ep0_tx_tog, ep0_rx_tog, ep2_rx_tog, ep_done_any;
  logic [31:0] rng = 32'h4;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int checked = 0;
  int setup_acks = 0;
  // clock generation
  always #10 core_clk = ~core_clk;
  uesc_top i_dut (.core_clk(core_clk), .arst_n(arst_n), .bus_reset(bus_reset),
    .force_iface_reset(force_iface_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_event(err_event),
    .err_code(err_code), .err_flag_clear(err_flag_clear), .ep0_setup(ep0_setup),
    .ep0_tx_ack(ep0_tx_ack), .ep0_rx_ok(ep0_rx_ok), .ep0_rx_pid(ep0_rx_pid),
    .ep0_stall_sent(ep0_stall_sent), .ep0_setup_ack(ep0_setup_ack), .ep_tx_ack(ep_tx_ack),
    .ep2_rx_ok(ep2_rx_ok), .ep2_rx_pid(ep2_rx_pid), .ep0_tx_hs(ep0_tx_hs),
    .ep0_rx_hs(ep0_rx_hs), .ep0_tx_tog(ep0_tx_tog), .ep0_rx_tog(ep0_rx_tog),
    .ep_tx_hs(ep_tx_hs), .ep_tx_tog(ep_tx_tog), .ep2_rx_hs(ep2_rx_hs),
    .ep2_rx_tog(ep2_rx_tog), .ep_done_any(ep_done_any));
  uesc_host_model i_host (.core_clk(core_clk), .bus_reset(bus_reset),
    .force_iface_reset(force_iface_reset), .err_event(err_event), .err_code(err_code),
    .err_flag_clear(err_flag_clear), .ep0_setup(ep0_setup), .ep0_tx_ack(ep0_tx_ack),
    .ep0_rx_ok(ep0_rx_ok), .ep0_rx_pid(ep0_rx_pid), .ep0_stall_sent(ep0_stall_sent),
    .ep_tx_ack(ep_tx_ack), .ep2_rx_ok(ep2_rx_ok), .ep2_rx_pid(ep2_rx_pid));
  // xorshift source for error codes
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // register read, expectation queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // verdict and end of run
  task automatic give_verdict();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read data monitor, samples the cycle after the strobe
  always @(posedge core_clk) rd_d <= reg_rd;
  // setup acknowledges are counted here, outside the read cycle data must be zero
  always @(negedge core_clk) begin
    if (ep0_setup_ack) setup_acks++;
    if (rd_d) begin
      if (exp_q.size() == 0) chk(reg_rdata, 8'hEE);
      else chk(reg_rdata, exp_q.pop_front());
    end else if (reg_rdata !== 8'h00) begin
      chk(reg_rdata, 8'h00);
    end
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 9; a++) rd(a[7:0], 8'h00);
    chk({ep0_tx_hs, ep0_rx_hs}, 8'h11);
    chk({ep2_rx_hs, ep_tx_hs[3:0]}, 8'h11);
    $display("test reset values done");
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h77);
    for (int i = 0; i < 5; i++) begin
      wr(8'h02 + i[7:0], 8'h0E);
      i_host.fire(6, i[2:0]);
      rd(8'h02 + i[7:0], 8'h06);
      wr(8'h02 + i[7:0], 8'h0F);
      rd(8'h02 + i[7:0], 8'h07);
      i_host.fire(6, i[2:0]);
      rd(8'h02 + i[7:0], 8'h0A);
      if (i == 0) chk({4'h0, ep_tx_hs[3:0]}, 8'h04);
      if (i == 0) chk({7'h00, ep_done_any}, 8'h01);
      wr(8'h02 + i[7:0], 8'h07);
      rd(8'h02 + i[7:0], 8'h07);
    end
    fork
      wr(8'h02, 8'h03);
      i_host.fire(6, 3'h0);
    join
    rd(8'h02, 8'h0A);
    chk({3'h0, ep_tx_tog}, 8'h1E);
    chk(ep_tx_hs[11:4], 8'h88);
    $display("test transmit endpoints done");
    wr(8'h01, 8'h33);
    i_host.fire(2, 3'h0);
    rd(8'h01, 8'hE2);
    chk({ep0_tx_hs, ep0_rx_hs}, 8'h44);
    chk({6'h00, ep0_tx_tog, ep0_rx_tog}, 8'h02);
    i_host.fire(5, 3'h0);
    rd(8'h01, 8'hD1);
    chk({ep0_tx_hs, ep0_rx_hs}, 8'h22);
    wr(8'h01, 8'h30);
    i_host.fire(3, 3'h0);
    rd(8'h01, 8'hE2);
    wr(8'h01, 8'h03);
    i_host.fire(4, 3'h1);
    rd(8'h01, 8'h03);
    i_host.fire(4, 3'h0);
    rd(8'h01, 8'hA6);
    $display("test endpoint 0 done");
    wr(8'h07, 8'h03);
    i_host.fire(7, 3'h0);
    rd(8'h07, 8'h0E);
    chk({ep2_rx_hs, 3'h0, ep2_rx_tog}, 8'h41);
    $display("test endpoint 2 receive done");
    for (int n = 0; n < 4; n++) begin
      rng = xs(rng);
      c = 3'(rng % 7);
      i_host.fire(0, c);
      rd(8'h00, {5'h00, c});
      i_host.fire(1, 3'h0);
      rd(8'h00, 8'h00);
    end
    i_host.fire(0, 3'h5);
    $display("test fault kind done");
    i_host.fire(8, 3'h0);
    rd(8'h01, 8'h80);
    wr(8'h01, 8'hF7);
    i_host.fire(9, 3'h0);
    rd(8'h01, 8'h80);
    rd(8'h02, 8'h08);
    rd(8'h07, 8'h08);
    rd(8'h00, 8'h05);
    i_host.fire(2, 3'h0);
    rd(8'h01, 8'h80);
    chk(setup_acks[7:0], 8'h01);
    $display("test interface resets done");
    repeat (3) @(posedge core_clk);
    give_verdict();
  end
endmodule
